/* File: logic/bbx_consts.svh */
`ifndef BBX_CONSTS_SVH
`define BBX_CONSTS_SVH

////////////////////////////////////////////////////////////////////////////////
// Register byte addresses
`define BBX_ADDR_CTRL   12'h000
`define BBX_ADDR_STATE  12'h004
`define BBX_ADDR_PC     12'h008
`define BBX_ADDR_FLAGS  12'h00C
`define BBX_ADDR_EXTENDED_INDIRECT_REGISTER   12'h010
`define BBX_ADDR_SP     12'h014
`define BBX_ADDR_COUNT  12'h018
`define BBX_WIN_GPR     5'h02
`define BBX_WIN_IO      5'h03
`define BBX_CTRL_RUN    0

////////////////////////////////////////////////////////////////////////////////
// Status flag positions
`define BBX_FL_C        3'h0
`define BBX_FL_Z        3'h1
`define BBX_FL_N        3'h2
`define BBX_FL_V        3'h3
`define BBX_FL_S        3'h4
`define BBX_FL_H        3'h5
`define BBX_FL_T        3'h6
`define BBX_FL_I        3'h7

////////////////////////////////////////////////////////////////////////////////
// Instruction classes in bits 15:12 and sub codes
`define BBX_OP_REG2     4'h0
`define BBX_OP_CMPI     4'h1
`define BBX_OP_UNARY    4'h2
`define BBX_OP_RBIT     4'h3
`define BBX_OP_IOBIT    4'h4
`define BBX_OP_BRANCH   4'h5
`define BBX_OP_JUMP     4'h6
`define BBX_R2_CMP      2'h0
`define BBX_R2_CMPC     2'h1
`define BBX_R2_COMPARE_SKIP_EQUAL     2'h2
`define BBX_UN_LSL      3'h0
`define BBX_UN_LSR      3'h1
`define BBX_UN_ROL      3'h2
`define BBX_UN_ROR      3'h3
`define BBX_UN_SWAP     3'h4
`define BBX_IO_SKC      2'h0
`define BBX_IO_SKS      2'h1
`define BBX_IO_ONE      2'h2
`define BBX_IO_ZERO     2'h3
`define BBX_JP_INDIRECT_JUMP     2'h0
`define BBX_JP_EXTENDED_INDIRECT_JUMP    2'h1
`define BBX_JP_INDIRECT_SUBROUTINE_CALL    2'h2
`define BBX_JP_EXTENDED_INDIRECT_SUBROUTINE_CALL   2'h3

////////////////////////////////////////////////////////////////////////////////
// Extra execute cycles beyond the first
`define BBX_XC_JUMP     2'h1
`define BBX_XC_CALL     2'h3
`define BBX_XC_BRANCH   2'h1
`define BBX_XC_IOFORCE  2'h1
`define BBX_XC_SKIP     2'h1

////////////////////////////////////////////////////////////////////////////////
// Bus answers
`define BBX_RESP_OKAY   2'h0
`define BBX_RESP_SLVERR 2'h2
`define BBX_RESP_DECERR 2'h3

`endif

/* File: logic/bbx_exec.sv */
// Our own choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/10ps
`include "bbx_consts.svh"

// What this block does
// RQ1: Indirect jump loads PC from Z pair; two cycles.
// RQ2: Extended indirect jump loads PC from extended register above Z; two cycles.
// RQ3: Indirect calls set PC from Z (extended form prefixed); four cycles each.
// RQ4: Compare-skip skips next instruction when registers equal; one to three cycles.
// RQ5: Compares subtract, set Z N V C H, write nothing; one cycle.
// RQ6: Register bit clear skip skips next when selected bit is zero.
// RQ7: Register bit set skip skips next when selected bit is one.
// RQ8: I/O bit skips test one I/O bit, skip on clear or set.
// RQ9: Generic flag branches go to PC+k+1 when flag s matches.
// RQ10: Equal branches on Z one, not-equal on Z zero.
// RQ11: Carry set and lower on C one; carry clear and same-or-higher on zero.
// RQ12: Minus branches on N one, plus on N zero.
// RQ13: Signed GE branches when N xor V is zero, LT when one.
// RQ14: Half-carry branches on H one or zero.
// RQ15: Transfer flag branches on T one or zero.
// RQ16: Overflow branches on V one or zero.
// RQ17: Interrupt branches on global enable one or zero.
// RQ18: I/O bit force one or zero, two cycles each.
// RQ19: Left shift moves bits up, zero into bit 0, sets Z C N V.
// RQ20: Right shift moves bits down, zero into bit 7, sets Z C N V.
// RQ21: Rotates through carry, old carry enters, leaving bit becomes carry.
// RQ22: Nibble exchange swaps halves, flags untouched, one cycle.
// RQ23: Calls push following address on stack before redirecting PC.
module bbx_exec #(
   parameter int PC_W        = 22,
   parameter int STACK_DEPTH = 16
) (
   // Clock and reset
   input  wire logic              aclk,
   input  wire logic              aresetn,
   // AXI4-Lite write
   input  wire logic [11:0]       awaddr,
   input  wire logic              awvalid,
   output logic                   awready,
   input  wire logic [31:0]       wdata,
   input  wire logic [3:0]        wstrb,
   input  wire logic              wvalid,
   output logic                   wready,
   output logic [1:0]             bresp,
   output logic                   bvalid,
   input  wire logic              bready,
   // AXI4-Lite read
   input  wire logic [11:0]       araddr,
   input  wire logic              arvalid,
   output logic                   arready,
   output logic [31:0]            rdata,
   output logic [1:0]             rresp,
   output logic                   rvalid,
   input  wire logic              rready,
   // Instruction fetch
   output logic                   fetch_req,
   output logic [PC_W-1:0]        fetch_addr,
   input  wire logic              instr_valid,
   input  wire logic [15:0]       instr_word,
   input  wire logic              instr_next_two
);
   import bbx_pkg::*;

   localparam int SP_W = (STACK_DEPTH > 1) ? $clog2(STACK_DEPTH) : 1;

   typedef struct packed {
      bbx_state_t                         st;
      logic                               run;
      logic [PC_W-1:0]                    pc;
      logic [7:0]                         flags;
      logic [7:0]                         extended_indirect_register;
      logic [SP_W-1:0]                    sp;
      logic [STACK_DEPTH-1:0][PC_W-1:0]   stk;
      logic [31:0][7:0]                   gpr;
      logic [31:0][7:0]                   io;
      logic [15:0]                        ir;
      logic                               nxt2;
      logic [1:0]                         wait_cnt;
      logic [31:0]                        icount;
      logic                               fetch_req;
      logic [PC_W-1:0]                    fetch_addr;
      logic                               aw_ok;
      logic [11:0]                        awa;
      logic                               w_ok;
      logic [31:0]                        wd;
      logic [3:0]                         ws;
      logic                               awready;
      logic                               wready;
      logic                               bvalid;
      logic [1:0]                         bresp;
      logic                               arready;
      logic                               rvalid;
      logic [1:0]                         rresp;
      logic [31:0]                        rdata;
   } bbx_regs_t;

   bbx_regs_t q;
   bbx_regs_t d;

   ////////////////////////////////////////////////////////////////////////////
   // Helpers

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // Carry-in form keeps Z only if it was already set
   function automatic logic [7:0] cmp_flags(input logic [7:0] a, input logic [7:0] b,
                                            input logic cin, input logic [7:0] f,
                                            input logic keepz);
      logic [8:0] r;
      logic [7:0] o;
      r = {1'b0, a} - {1'b0, b} - {8'h00, cin};
      o = f;
      o[`BBX_FL_C] = r[8];
      o[`BBX_FL_H] = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
      o[`BBX_FL_V] = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
      o[`BBX_FL_N] = r[7];
      o[`BBX_FL_Z] = (r[7:0] == 8'h00) & (~keepz | f[`BBX_FL_Z]);
      o[`BBX_FL_S] = o[`BBX_FL_N] ^ o[`BBX_FL_V];
      return o;
   endfunction

   function automatic logic [7:0] shift_flags(input logic [7:0] r, input logic c,
                                              input logic [7:0] f);
      logic [7:0] o;
      o = f;
      o[`BBX_FL_C] = c;
      o[`BBX_FL_Z] = (r == 8'h00);
      o[`BBX_FL_N] = r[7];
      o[`BBX_FL_V] = r[7] ^ c;
      o[`BBX_FL_S] = o[`BBX_FL_N] ^ o[`BBX_FL_V];
      return o;
   endfunction

   // Signed test is taken live from N and V so it can never go stale
   function automatic logic flag_sel(input logic [2:0] s, input logic [7:0] f);
      logic r;
      r = 1'b0;
      case (s)
         `BBX_FL_C: r = f[`BBX_FL_C];                // [RQ11]
         `BBX_FL_Z: r = f[`BBX_FL_Z];                // [RQ10]
         `BBX_FL_N: r = f[`BBX_FL_N];                // [RQ12]
         `BBX_FL_V: r = f[`BBX_FL_V];                // [RQ16]
         `BBX_FL_S: r = f[`BBX_FL_N] ^ f[`BBX_FL_V]; // [RQ13]
         `BBX_FL_H: r = f[`BBX_FL_H];                // [RQ14]
         `BBX_FL_T: r = f[`BBX_FL_T];                // [RQ15]
         `BBX_FL_I: r = f[`BBX_FL_I];                // [RQ17]
         default:   r = 1'b0;
      endcase
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      logic        bus_wr, halted, c1, skip, go_next;
      logic [4:0]  ra, rb;
      logic [7:0]  a, b, r8;
      logic [15:0] z;
      bus_wr  = 1'b0;
      halted  = 1'b0;
      ra      = 5'h00;
      rb      = 5'h00;
      a       = 8'h00;
      b       = 8'h00;
      r8      = 8'h00;
      c1      = 1'b0;
      skip    = 1'b0;
      go_next = 1'b0;
      z       = 16'h0000;
      d       = q;

      // Write channel: address and data taken in either order
      if (q.awready && awvalid) begin
         d.aw_ok = 1'b1;
         d.awa   = awaddr;
      end
      if (q.wready && wvalid) begin
         d.w_ok = 1'b1;
         d.wd   = wdata;
         d.ws   = wstrb;
      end
      if (q.bvalid && bready) d.bvalid = 1'b0;
      halted = (q.st == bbx_st_idle) && !q.run;
      bus_wr = q.aw_ok && q.w_ok && !q.bvalid;
      if (bus_wr) begin
         d.aw_ok  = 1'b0;
         d.w_ok   = 1'b0;
         d.bvalid = 1'b1;
         d.bresp  = `BBX_RESP_OKAY;
         // Core state is writable only while halted
         case (q.awa)
            `BBX_ADDR_CTRL: begin
               if (q.ws[0]) begin
                  d.run = q.wd[`BBX_CTRL_RUN];
               end
            end
            `BBX_ADDR_PC: begin
               if (halted) begin
                  d.pc = PC_W'(merge(32'(q.pc), q.wd, q.ws));
               end else begin
                  d.bresp = `BBX_RESP_SLVERR;
               end
            end
            `BBX_ADDR_FLAGS: begin
               if (halted) begin
                  d.flags = q.ws[0] ? q.wd[7:0] : q.flags;
               end else begin
                  d.bresp = `BBX_RESP_SLVERR;
               end
            end
            `BBX_ADDR_EXTENDED_INDIRECT_REGISTER: begin
               if (halted) begin
                  d.extended_indirect_register = q.ws[0] ? q.wd[7:0] : q.extended_indirect_register;
               end else begin
                  d.bresp = `BBX_RESP_SLVERR;
               end
            end
            `BBX_ADDR_STATE, `BBX_ADDR_SP, `BBX_ADDR_COUNT: begin
               d.bresp = `BBX_RESP_SLVERR;
            end
            default: begin
               if (q.awa[11:7] == `BBX_WIN_GPR && q.awa[1:0] == 2'h0 && halted) begin
                  if (q.ws[0]) begin
                     d.gpr[q.awa[6:2]] = q.wd[7:0];
                  end
               end else if (q.awa[11:7] == `BBX_WIN_IO && q.awa[1:0] == 2'h0 && halted) begin
                  if (q.ws[0]) begin
                     d.io[q.awa[6:2]] = q.wd[7:0];
                  end
               end else if (q.awa[11:8] == 4'h1 && q.awa[1:0] == 2'h0) begin
                  d.bresp = `BBX_RESP_SLVERR;
               end else begin
                  d.bresp = `BBX_RESP_DECERR;
               end
            end
         endcase
      end
      d.awready = !d.aw_ok;
      d.wready  = !d.w_ok;

      // Read channel
      if (q.rvalid && rready) d.rvalid = 1'b0;
      if (q.arready && arvalid) begin
         d.rvalid = 1'b1;
         d.rresp  = `BBX_RESP_OKAY;
         d.rdata  = 32'h0000_0000;
         case (araddr)
            `BBX_ADDR_CTRL:  d.rdata = {31'h0000_0000, q.run};
            `BBX_ADDR_STATE: d.rdata = {28'h000_0000, q.st};
            `BBX_ADDR_PC:    d.rdata = 32'(q.pc);
            `BBX_ADDR_FLAGS: d.rdata = {24'h00_0000, q.flags};
            `BBX_ADDR_EXTENDED_INDIRECT_REGISTER:  d.rdata = {24'h00_0000, q.extended_indirect_register};
            `BBX_ADDR_SP:    d.rdata = 32'(q.sp);
            `BBX_ADDR_COUNT: d.rdata = q.icount;
            default: begin
               if (araddr[11:7] == `BBX_WIN_GPR && araddr[1:0] == 2'h0) begin
                  d.rdata = {24'h00_0000, q.gpr[araddr[6:2]]};
               end else if (araddr[11:7] == `BBX_WIN_IO && araddr[1:0] == 2'h0) begin
                  d.rdata = {24'h00_0000, q.io[araddr[6:2]]};
               end else begin
                  d.rresp = `BBX_RESP_DECERR;
               end
            end
         endcase
      end
      d.arready = !d.rvalid;

      ////////////////////////////////////////////////////////////////////////
      // Execution sequencer
      case (q.st)
         bbx_st_idle: begin
            if (q.run) begin
               d.st         = bbx_st_fetch;
               d.fetch_req  = 1'b1;
               d.fetch_addr = q.pc;
            end
         end
         bbx_st_fetch: begin
            if (q.fetch_req && instr_valid) begin
               d.ir        = instr_word;
               d.nxt2      = instr_next_two;
               d.fetch_req = 1'b0;
               d.st        = bbx_st_exec;
            end
         end
         bbx_st_exec: begin
            d.icount   = q.icount + 32'h0000_0001;
            d.wait_cnt = 2'h0;
            d.pc       = q.pc + PC_W'(1);
            ra         = q.ir[9:5];
            rb         = q.ir[4:0];
            z          = {q.gpr[31], q.gpr[30]};
            case (q.ir[15:12])
               `BBX_OP_REG2: begin
                  a = q.gpr[ra];
                  b = q.gpr[rb];
                  case (q.ir[11:10])
                     `BBX_R2_CMP:  d.flags = cmp_flags(a, b, 1'b0, q.flags, 1'b0); // [RQ5]
                     `BBX_R2_CMPC: begin
                        d.flags = cmp_flags(a, b, q.flags[`BBX_FL_C], q.flags, 1'b1); // [RQ5]
                     end
                     `BBX_R2_COMPARE_SKIP_EQUAL: skip = (a == b); // [RQ4]
                     default: ;
                  endcase
               end
               `BBX_OP_CMPI: begin
                  a       = q.gpr[{1'b1, q.ir[11:8]}];
                  d.flags = cmp_flags(a, q.ir[7:0], 1'b0, q.flags, 1'b0); // [RQ5]
               end
               `BBX_OP_UNARY: begin
                  a  = q.gpr[rb];
                  r8 = a;
                  c1 = q.flags[`BBX_FL_C];
                  case (q.ir[11:9])
                     `BBX_UN_LSL: begin
                        r8 = {a[6:0], 1'b0}; // [RQ19]
                        c1 = a[7];
                     end
                     `BBX_UN_LSR: begin
                        r8 = {1'b0, a[7:1]}; // [RQ20]
                        c1 = a[0];
                     end
                     `BBX_UN_ROL: begin
                        r8 = {a[6:0], q.flags[`BBX_FL_C]}; // [RQ21]
                        c1 = a[7];
                     end
                     `BBX_UN_ROR: begin
                        r8 = {q.flags[`BBX_FL_C], a[7:1]}; // [RQ21]
                        c1 = a[0];
                     end
                     `BBX_UN_SWAP: r8 = {a[3:0], a[7:4]}; // [RQ22]
                     default: ;
                  endcase
                  d.gpr[rb] = r8;
                  if (q.ir[11:9] != `BBX_UN_SWAP && q.ir[11:9] <= `BBX_UN_ROR) begin
                     d.flags = shift_flags(r8, c1, q.flags); // [RQ19] [RQ20] [RQ21]
                  end
               end
               `BBX_OP_RBIT: begin
                  a    = q.gpr[q.ir[7:3]];
                  skip = (a[q.ir[2:0]] == q.ir[8]); // [RQ6] [RQ7]
               end
               `BBX_OP_IOBIT: begin
                  a = q.io[q.ir[7:3]];
                  case (q.ir[9:8])
                     `BBX_IO_SKC: skip = !a[q.ir[2:0]]; // [RQ8]
                     `BBX_IO_SKS: skip = a[q.ir[2:0]];  // [RQ8]
                     default: begin
                        // The rest of the byte is kept
                        d.io[q.ir[7:3]][q.ir[2:0]] = (q.ir[9:8] == `BBX_IO_ONE); // [RQ18]
                        d.wait_cnt = `BBX_XC_IOFORCE; // [RQ18]
                     end
                  endcase
               end
               `BBX_OP_BRANCH: begin
                  if (flag_sel(q.ir[10:8], q.flags) != q.ir[11]) begin
                     d.pc = q.pc + {{(PC_W-8){q.ir[7]}}, q.ir[7:0]} + PC_W'(1); // [RQ9]
                     d.wait_cnt = `BBX_XC_BRANCH; // [RQ9]
                  end
               end
               `BBX_OP_JUMP: begin
                  if (q.ir[0]) begin
                     d.pc = PC_W'({q.extended_indirect_register, z}); // [RQ2] [RQ3]
                  end else begin
                     d.pc = PC_W'(z); // [RQ1] [RQ3]
                  end
                  if (q.ir[1]) begin
                     // Stack wraps; deep nesting overwrites the oldest entry
                     d.stk[q.sp] = q.pc + PC_W'(1); // [RQ23]
                     d.sp        = q.sp + SP_W'(1); // [RQ23]
                     d.wait_cnt  = `BBX_XC_CALL; // [RQ3]
                  end else begin
                     d.wait_cnt  = `BBX_XC_JUMP; // [RQ1] [RQ2]
                  end
               end
               default: ;
            endcase
            if (skip) begin
               d.pc       = q.pc + PC_W'(2) + PC_W'(q.nxt2); // [RQ4] [RQ6] [RQ7] [RQ8]
               d.wait_cnt = `BBX_XC_SKIP + {1'b0, q.nxt2};   // [RQ4] [RQ6] [RQ7] [RQ8]
            end
            if (d.wait_cnt != 2'h0) begin
               d.st = bbx_st_wait;
            end else begin
               go_next = 1'b1;
            end
         end
         bbx_st_wait: begin
            if (q.wait_cnt == 2'h1) go_next = 1'b1;
            d.wait_cnt = q.wait_cnt - 2'h1;
         end
         default: d.st = bbx_st_idle;
      endcase

      if (go_next) begin
         if (q.run) begin
            d.st         = bbx_st_fetch;
            d.fetch_req  = 1'b1;
            d.fetch_addr = d.pc;
         end else begin
            d.st = bbx_st_idle;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q    <= '0;
         q.st <= bbx_st_idle;
      end else begin
         q <= d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs
   assign awready    = q.awready;
   assign wready     = q.wready;
   assign bvalid     = q.bvalid;
   assign bresp      = q.bresp;
   assign arready    = q.arready;
   assign rvalid     = q.rvalid;
   assign rresp      = q.rresp;
   assign rdata      = q.rdata;
   assign fetch_req  = q.fetch_req;
   assign fetch_addr = q.fetch_addr;

endmodule

/* File: logic/bbx_pkg.sv */
package bbx_pkg;
   typedef enum logic [3:0] {
      bbx_st_idle  = 4'h1,
      bbx_st_fetch = 4'h2,
      bbx_st_exec  = 4'h4,
      bbx_st_wait  = 4'h8
   } bbx_state_t;
endpackage

/* File: verification/bbx_exec_properties.sv */
`timescale 1ns/10ps
module bbx_exec_properties #(
   parameter int PC_W = 22
) (
   // Watched ports
   input wire logic            aclk,
   input wire logic            aresetn,
   input wire logic            awvalid,
   input wire logic            awready,
   input wire logic            wvalid,
   input wire logic            wready,
   input wire logic [1:0]      bresp,
   input wire logic            bvalid,
   input wire logic            bready,
   input wire logic            arvalid,
   input wire logic            arready,
   input wire logic [31:0]     rdata,
   input wire logic            rvalid,
   input wire logic            rready,
   input wire logic            fetch_req,
   input wire logic [PC_W-1:0] fetch_addr,
   input wire logic            instr_valid,
   input wire logic [15:0]     instr_word
);
   wire [3:0] cls = instr_word[15:12];
   wire       one_c = (cls == 4'h0 && instr_word[11:10] != 2'h2) || cls == 4'h1 || cls == 4'h2;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_tk; fetch_req && instr_valid; endsequence
   sequence s_gap2; !fetch_req [*2] ##1 fetch_req; endsequence
   property p_one; s_tk ##0 one_c |=> !fetch_req ##1 fetch_req; endproperty
   a_one: assert property (p_one) else $error("single cycle op mistimed");
   property p_jump; s_tk ##0 (cls == 4'h6 && !instr_word[1]) |=> s_gap2; endproperty
   a_jump: assert property (p_jump) else $error("jump not two cycles");
   property p_call; s_tk ##0 (cls == 4'h6 && instr_word[1]) |=> !fetch_req [*4] ##1 fetch_req;
   endproperty
   a_call: assert property (p_call) else $error("call not four cycles");
   property p_force; s_tk ##0 (cls == 4'h4 && instr_word[9]) |=> s_gap2; endproperty
   a_force: assert property (p_force) else $error("bit force not two cycles");
   property p_fhold; fetch_req && !instr_valid |=> fetch_req && $stable(fetch_addr); endproperty
   a_fhold: assert property (p_fhold) else $error("fetch request not held");
   property p_fdrop; s_tk |=> !fetch_req; endproperty
   a_fdrop: assert property (p_fdrop) else $error("fetch request not dropped");
   property p_bhold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
   a_bhold: assert property (p_bhold) else $error("write answer not held");
   property p_rhold; rvalid && !rready |=> rvalid && $stable(rdata); endproperty
   a_rhold: assert property (p_rhold) else $error("read answer not held");
   property p_rans; arvalid && arready |=> rvalid; endproperty
   a_rans: assert property (p_rans) else $error("read answer late");
   property p_bans; awvalid && awready && wvalid && wready |=> ##1 bvalid; endproperty
   a_bans: assert property (p_bans) else $error("write answer late");
endmodule

/* File: verification/bbx_imem.sv */
`timescale 1ns/10ps
module bbx_imem #(
   parameter int PC_W = 22
) (
   // Clock and reset
   input wire logic            aclk,
   input wire logic            aresetn,
   // Fetch side
   input wire logic            fetch_req,
   input wire logic [PC_W-1:0] fetch_addr,
   output logic                instr_valid,
   output logic [15:0]         instr_word,
   output logic                instr_next_two
);
   logic [15:0] mem [0:15];
   int          wait_q = 0;
   initial instr_valid = 1'b0;
   initial instr_word = 16'hA55A;
   // No two-word instructions in the test image
   assign instr_next_two = 1'b0;
   // Random latency; the word toggles while idle
   always @(posedge aclk) begin
      if (!aresetn || (instr_valid && fetch_req) || !fetch_req) begin
         instr_valid <= 1'b0;
         instr_word  <= ~instr_word;
         wait_q      <= $urandom_range(2);
      end else if (wait_q > 0) begin
         wait_q <= wait_q - 1;
      end else begin
         instr_valid <= 1'b1;
         instr_word  <= mem[fetch_addr[3:0]];
      end
   end
endmodule

/* File: verification/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic [11:0] awaddr = 12'h000, araddr = 12'h000;
   logic [31:0] wdata = 32'h0;
   logic [3:0]  wstrb = 4'hF;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid, fetch_req, instr_valid, instr_next_two;
   logic [1:0]  bresp, rresp;
   logic [31:0] rdata;
   logic [21:0] fetch_addr;
   logic [15:0] instr_word;
   logic [33:0] rd_q [$];
   logic [1:0]  wr_q [$];
   int          n_fail = 0, num_checks = 0, cyc = 0;
   always #4 aclk = ~aclk;
   bbx_exec #(.PC_W(22), .STACK_DEPTH(16)) DUT (.aclk, .aresetn, .awaddr, .awvalid, .awready,
      .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
      .rdata, .rresp, .rvalid, .rready, .fetch_req, .fetch_addr, .instr_valid, .instr_word,
      .instr_next_two);
   bbx_imem #(.PC_W(22)) u_mem (.aclk, .aresetn, .fetch_req, .fetch_addr, .instr_valid,
      .instr_word, .instr_next_two);
   ////////////////////////////////////////////////////////////
   task automatic fail(string m);
      n_fail++;
      $display("[ERR] %0t %s", $time, m);
   endtask
   task automatic chk_rd(logic [33:0] got, logic [33:0] exp);
      num_checks++;
      if (got !== exp) fail($sformatf("read %h want %h", got, exp));
   endtask
   task automatic chk_wr(logic [1:0] got, logic [1:0] exp);
      num_checks++;
      if (got !== exp) fail($sformatf("bresp %h want %h", got, exp));
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // Answers pop the drivers' notes in arrival order
   always @(posedge aclk) begin
      cyc++;
      if (bvalid && bready) chk_wr(bresp, wr_q.pop_front());
      if (rvalid && rready) chk_rd({rresp, rdata}, rd_q.pop_front());
      if (cyc == 20000) begin
         fail("timeout");
         summarize();
      end
   end
   task automatic wr(logic [11:0] a, logic [7:0] d, logic [1:0] e);
      wr_q.push_back(e);
      awaddr  <= a;
      wdata   <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'($urandom);
      do begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid && !bready) bready <= 1'b1;
      end while (!(bvalid && bready));
   endtask
   task automatic rd(logic [11:0] a, logic [31:0] d, logic [1:0] e);
      rd_q.push_back({e, d});
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'($urandom);
      do begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid && !rready) rready <= 1'b1;
      end while (!(rvalid && rready));
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      logic [7:0] v [0:5];
      logic [7:0] fl, ef, rr, io;
      logic [8:0] d;
      logic [2:0] bt;
      void'($urandom(34193));
      u_mem.mem = '{0: 16'h0022, 1: 16'h5101, 2: 16'h2003, 3: 16'h2804, 4: 16'h3128,
                    8: 16'h5EFF, default: 16'h7000};
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      rd(12'h004, 32'h1, 2'h0);
      rd(12'h008, 32'h0, 2'h0);
      rd(12'h020, 32'h0, 2'h3);
      wr(12'h014, 8'h05, 2'h2);
      $display("test reset and map done");
      for (int i = 0; i < 4; i++) begin
         for (int n = 1; n < 5; n++) v[n] = 8'($urandom);
         if (i[0]) v[2] = v[1];
         else if (v[2] == v[1]) v[2] = ~v[1];
         v[5] = {7'($urandom), i[1]};
         fl = 8'($urandom) & 8'hBF;
         io = 8'($urandom);
         bt = 3'($urandom);
         u_mem.mem[5] = 16'h4218 | {13'h0, bt};
         u_mem.mem[6] = i[0] ? 16'h6003 : 16'h6000;
         for (int n = 1; n < 6; n++) wr(12'h100 + 12'(4 * n), v[n], 2'h0);
         wr(12'h178, 8'h08, 2'h0);
         wr(12'h17C, 8'h00, 2'h0);
         wr(12'h010, 8'h00, 2'h0);
         wr(12'h18C, io, 2'h0);
         wr(12'h00C, fl, 2'h0);
         wr(12'h008, 8'h00, 2'h0);
         wr(12'h000, 8'h01, 2'h0);
         wr(12'h00C, 8'hFF, 2'h2);
         while (!(fetch_req && fetch_addr == 22'h8)) @(posedge aclk);
         wr(12'h000, 8'h00, 2'h0);
         repeat (8) @(posedge aclk);
         d = {1'b0, v[1]} - {1'b0, v[2]};
         ef = fl;
         ef[0] = d[8];
         ef[1] = d[7:0] == 8'h00;
         ef[2] = d[7];
         ef[3] = (v[1][7] & ~v[2][7] & ~d[7]) | (~v[1][7] & v[2][7] & d[7]);
         ef[5] = (~v[1][3] & v[2][3]) | (v[2][3] & d[3]) | (d[3] & ~v[1][3]);
         rr = v[3];
         if (!i[0]) begin
            rr = {v[3][6:0], 1'b0};
            ef[0] = v[3][7];
            ef[1] = rr == 8'h00;
            ef[2] = rr[7];
            ef[3] = rr[7] ^ v[3][7];
         end
         ef[4] = ef[2] ^ ef[3];
         if (!i[1]) io = io | (8'h01 << bt);
         rd(12'h008, 32'h8, 2'h0);
         rd(12'h00C, {24'h0, ef}, 2'h0);
         rd(12'h104, {24'h0, v[1]}, 2'h0);
         rd(12'h10C, {24'h0, rr}, 2'h0);
         rd(12'h110, {24'h0, v[4][3:0], v[4][7:4]}, 2'h0);
         rd(12'h18C, {24'h0, io}, 2'h0);
         rd(12'h014, 32'((i + 1) / 2), 2'h0);
         $display("test program pass %0d done", i);
      end
      summarize();
   end
endmodule
bind bbx_exec bbx_exec_properties #(.PC_W(PC_W)) u_props (.aclk, .aresetn, .awvalid, .awready,
   .wvalid, .wready, .bresp, .bvalid, .bready, .arvalid, .arready, .rdata, .rvalid, .rready,
   .fetch_req, .fetch_addr, .instr_valid, .instr_word);
